// File: pkg/pfp_map.svh
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH

// apb register byte offsets
`define PFP_OFS_PROT 12'h000
`define PFP_OFS_STAT 12'h004
`define PFP_OFS_SCEN 12'h008

// status register field positions
`define PFP_STAT_LOADED 0
`define PFP_STAT_LOAD_FAULT 1
`define PFP_STAT_VIOL 4

// nonvolatile protection byte and its fault substitute
`define PFP_NV_ADDR 24'hFF_FE0C
`define PFP_FAULT_VAL 8'h7F
`define PFP_PROT_RST 8'h7F

// range geometry
`define PFP_TOP_ADDR 24'hFF_FFFF
`define PFP_LOW_BASE 24'hFF_8000
`define PFP_HI_UNIT 24'h00_0800
`define PFP_LO_UNIT 24'h00_0400
`define PFP_ADDR_ONE 24'h00_0001

// allowed target scenarios, bit n set means scenario n may follow
`define PFP_TR0 8'h0F
`define PFP_TR1 8'h0A
`define PFP_TR2 8'h0C
`define PFP_TR3 8'h08
`define PFP_TR4 8'h18
`define PFP_TR5 8'h3C
`define PFP_TR6 8'h5A
`define PFP_TR7 8'hFF

`endif

// File: pkg/pfp_pkg.sv
package pfp_pkg;

	typedef struct packed {
		logic protect_operation_enable;
		logic reserved_nonvolatile_bit;
		logic high_range_disable;
		logic [1:0] high_range_size;
		logic low_range_disable;
		logic [1:0] low_range_size;
	} pfp_prot_t;

	typedef enum logic [1:0] {
		PFP_OP_PROGRAM = 2'h0,
		PFP_OP_SECTOR_ERASE = 2'h1,
		PFP_OP_BLOCK_ERASE = 2'h2,
		PFP_OP_OTHER = 2'h3
	} pfp_op_t;

	typedef struct packed {
		pfp_op_t op;
		logic [23:0] addr;
	} pfp_cmd_t;

	typedef enum logic [1:0] {
		PFP_LOAD_REQ,
		PFP_LOAD_WAIT,
		PFP_RUN
	} pfp_load_t;

endpackage : pfp_pkg

// File: rtl/pfp_protect.sv
`timescale 1ns/1ps
`include "pfp_map.svh"

module pfp_protect import pfp_pkg::*; #(
	parameter logic [23:0] PFLASH_BASE = 24'hFF_8000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic special_mode,
	output logic nv_rd_req,
	output logic [23:0] nv_rd_addr,
	input wire logic nv_rd_valid,
	input wire logic [7:0] nv_rd_data,
	input wire logic nv_dbl_fault,
	input wire logic cmd_valid,
	input wire pfp_cmd_t cmd,
	output logic cmd_done,
	output logic cmd_refused,
	output logic protection_violation_flag,
	output pfp_prot_t prot_cfg
);

	pfp_load_t load_ff;
	logic nv_rd_req_ff;
	pfp_prot_t prot_ff;
	pfp_prot_t nxt_prot;
	pfp_prot_t cand;
	logic load_fault_ff;
	logic viol_ff;
	logic nxt_viol;
	logic cmd_done_ff;
	logic cmd_refused_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	logic run;
	logic acc;
	logic wr_take;
	logic rd_take;
	logic sel_prot;
	logic sel_stat;
	logic sel_scen;
	logic wr_ok;
	logic [23:0] hi_start;
	logic [23:0] lo_end;
	logic in_pf;
	logic in_hi;
	logic in_lo;
	logic rng_hit;
	logic prot_hit;
	logic any_prot;
	logic is_alter;
	logic is_blk;
	logic viol_set;
	logic viol_clr;

	// scenario index of an enable/flag combination
	function automatic logic [2:0] scen_of(input pfp_prot_t p);
		logic [2:0] s;
		s = 3'h0;
		case ({p.protect_operation_enable, p.high_range_disable,
			p.low_range_disable})
			3'b000: s = 3'h0;
			3'b010: s = 3'h1;
			3'b001: s = 3'h2;
			3'b011: s = 3'h3;
			3'b100: s = 3'h4;
			3'b110: s = 3'h5;
			3'b101: s = 3'h6;
			3'b111: s = 3'h7;
			default: s = 3'h3;
		endcase
		return s;
	endfunction : scen_of

	function automatic logic tr_ok(input logic [2:0] from,
		input logic [2:0] to);
		logic [7:0] m;
		m = 8'h00;
		case (from)
			3'h0: m = `PFP_TR0;
			3'h1: m = `PFP_TR1;
			3'h2: m = `PFP_TR2;
			3'h3: m = `PFP_TR3;
			3'h4: m = `PFP_TR4;
			3'h5: m = `PFP_TR5;
			3'h6: m = `PFP_TR6;
			3'h7: m = `PFP_TR7;
			default: m = 8'h00;
		endcase
		return m[to];
	endfunction : tr_ok

	assign run = (load_ff == PFP_RUN);
	// registers stall until the reset load has finished
	assign acc = psel & penable & ~pready_ff & run;
	// writes land on the completion edge, where pready is sampled high
	assign wr_take = psel & penable & pready_ff & pwrite;
	assign rd_take = acc & ~pwrite;
	assign sel_prot = (paddr == `PFP_OFS_PROT);
	assign sel_stat = (paddr == `PFP_OFS_STAT);
	assign sel_scen = (paddr == `PFP_OFS_SCEN);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_ff <= PFP_LOAD_REQ;
			nv_rd_req_ff <= 1'b0;
		end else begin
			case (load_ff)
				PFP_LOAD_REQ: begin
					nv_rd_req_ff <= 1'b1;
					load_ff <= PFP_LOAD_WAIT;
				end
				PFP_LOAD_WAIT: begin
					if (nv_rd_valid) begin
						nv_rd_req_ff <= 1'b0;
						load_ff <= PFP_RUN;
					end
				end
				PFP_RUN: begin
					load_ff <= PFP_RUN;
				end
				default: begin
					load_ff <= PFP_LOAD_REQ;
				end
			endcase
		end
	end

	always_comb begin
		cand = prot_ff;
		cand.protect_operation_enable = pwdata[7];
		cand.high_range_disable = pwdata[5];
		cand.low_range_disable = pwdata[2];
		if (special_mode) begin
			cand.high_range_size = pwdata[4:3];
			cand.low_range_size = pwdata[1:0];
		end else begin
			if (prot_ff.high_range_disable) begin
				cand.high_range_size = pwdata[4:3];
			end
			if (prot_ff.low_range_disable) begin
				cand.low_range_size = pwdata[1:0];
			end
		end
	end

	// a refused write is dropped whole, never applied in part
	assign wr_ok = special_mode | tr_ok(scen_of(prot_ff), scen_of(cand));

	always_comb begin
		nxt_prot = prot_ff;
		if (wr_take && sel_prot && wr_ok) begin
			nxt_prot = cand;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prot_ff <= `PFP_PROT_RST;
			load_fault_ff <= 1'b0;
		end else if (load_ff == PFP_LOAD_WAIT) begin
			if (nv_rd_valid && nv_dbl_fault) begin
				prot_ff <= `PFP_FAULT_VAL;
				load_fault_ff <= 1'b1;
			end else if (nv_rd_valid) begin
				prot_ff <= nv_rd_data;
			end
		end else begin
			prot_ff <= nxt_prot;
		end
	end

	// range bounds; both ranges end or start at fixed addresses
	assign hi_start = `PFP_TOP_ADDR -
		((`PFP_HI_UNIT << prot_ff.high_range_size) - `PFP_ADDR_ONE);
	assign lo_end = `PFP_LOW_BASE +
		((`PFP_LO_UNIT << prot_ff.low_range_size) - `PFP_ADDR_ONE);
	assign in_pf = (cmd.addr >= PFLASH_BASE);
	assign in_hi = (cmd.addr >= hi_start);
	assign in_lo = (cmd.addr >= `PFP_LOW_BASE) && (cmd.addr <= lo_end);
	assign rng_hit = (~prot_ff.high_range_disable & in_hi) |
		(~prot_ff.low_range_disable & in_lo);
	assign prot_hit = in_pf & (prot_ff.protect_operation_enable ?
		rng_hit : ~rng_hit);
	// with enable low the open ranges never cover the whole block
	assign any_prot = prot_ff.protect_operation_enable ?
		(~prot_ff.high_range_disable | ~prot_ff.low_range_disable) :
		1'b1;
	assign is_alter = (cmd.op == PFP_OP_PROGRAM) |
		(cmd.op == PFP_OP_SECTOR_ERASE);
	assign is_blk = (cmd.op == PFP_OP_BLOCK_ERASE) & in_pf;
	assign viol_set = cmd_valid & run & ~viol_ff &
		((is_alter & prot_hit) | (is_blk & any_prot));
	assign viol_clr = wr_take & sel_stat & pwdata[`PFP_STAT_VIOL];
	// a clear of a set flag wins; a new violation only sets the flag while it is clear
	assign nxt_viol = viol_set | (viol_ff & ~viol_clr);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			viol_ff <= 1'b0;
		end else begin
			viol_ff <= nxt_viol;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_done_ff <= 1'b0;
			cmd_refused_ff <= 1'b0;
		end else begin
			cmd_done_ff <= cmd_valid;
			cmd_refused_ff <= cmd_valid & (~run | viol_ff |
				(is_alter & prot_hit) | (is_blk & any_prot));
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc & ~(sel_prot | sel_stat | sel_scen);
			prdata_ff <= 32'h0000_0000;
			if (rd_take && sel_prot) begin
				prdata_ff <= {24'h00_0000, prot_ff};
			end else if (rd_take && sel_stat) begin
				prdata_ff[`PFP_STAT_LOADED] <= run;
				prdata_ff[`PFP_STAT_LOAD_FAULT] <= load_fault_ff;
				prdata_ff[`PFP_STAT_VIOL] <= viol_ff;
			end else if (rd_take && sel_scen) begin
				prdata_ff <= {29'h0, scen_of(prot_ff)};
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign nv_rd_req = nv_rd_req_ff;
	assign nv_rd_addr = `PFP_NV_ADDR;
	assign cmd_done = cmd_done_ff;
	assign cmd_refused = cmd_refused_ff;
	assign protection_violation_flag = viol_ff;
	assign prot_cfg = prot_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_fault_load: assert property (
		load_ff == PFP_LOAD_WAIT && nv_rd_valid && nv_dbl_fault
		|=> prot_ff == `PFP_FAULT_VAL && run && !nv_rd_req_ff
	) else $error("fault load did not fully protect");

	a_nv_load: assert property (
		load_ff == PFP_LOAD_WAIT && nv_rd_valid && !nv_dbl_fault
		|=> prot_ff == $past(nv_rd_data) && run
	) else $error("protection byte not loaded");

	a_bad_write_kept: assert property (
		wr_take && sel_prot && !special_mode &&
		!tr_ok(scen_of(prot_ff), scen_of(cand))
		|=> $stable(prot_ff)
	) else $error("disallowed write changed register");

	a_scen_legal: assert property (
		wr_take && sel_prot && !special_mode &&
		tr_ok(scen_of(prot_ff), scen_of(cand))
		|=> prot_ff == $past(cand)
	) else $error("allowed write not applied");

	a_normal_grow: assert property (
		wr_take && sel_prot && !special_mode
		|=> tr_ok(scen_of($past(prot_ff)), scen_of(prot_ff))
	) else $error("normal mode write reduced protection");

	a_special_free: assert property (
		wr_take && sel_prot && special_mode
		|=> prot_ff[7] == $past(pwdata[7]) &&
		prot_ff[5:0] == $past(pwdata[5:0])
	) else $error("special mode write not taken");

	a_high_size_lock: assert property (
		wr_take && sel_prot && !special_mode &&
		!prot_ff.high_range_disable
		|=> prot_ff.high_range_size == $past(prot_ff.high_range_size)
	) else $error("high size changed while range active");

	a_low_size_lock: assert property (
		wr_take && sel_prot && !special_mode &&
		!prot_ff.low_range_disable
		|=> prot_ff.low_range_size == $past(prot_ff.low_range_size)
	) else $error("low size changed while range active");

	a_viol_wins: assert property (
		viol_set
		|=> viol_ff
	) else $error("violation lost to a clear");

	a_top_range: assert property (
		cmd_valid && run && !viol_ff && is_alter &&
		prot_ff.protect_operation_enable && !prot_ff.high_range_disable &&
		cmd.addr == `PFP_TOP_ADDR
		|=> cmd_refused_ff && viol_ff
	) else $error("top address not protected");

	a_low_base: assert property (
		cmd_valid && run && !viol_ff && is_alter &&
		prot_ff.protect_operation_enable && !prot_ff.low_range_disable &&
		cmd.addr == `PFP_LOW_BASE
		|=> cmd_refused_ff && viol_ff
	) else $error("low base address not protected");

	a_viol_sets: assert property (
		cmd_valid && run && !viol_ff && is_alter && prot_hit
		|=> viol_ff && cmd_refused_ff && cmd_done_ff
	) else $error("protected program not flagged");

	a_block_erase: assert property (
		cmd_valid && is_blk && any_prot
		|=> cmd_refused_ff
	) else $error("block erase allowed with protection");

	a_flag_blocks: assert property (
		cmd_valid && viol_ff
		|=> cmd_refused_ff && cmd_done_ff
	) else $error("command accepted while flag set");

	a_read_value: assert property (
		rd_take && sel_prot
		|=> pready_ff && prdata_ff == {24'h00_0000, $past(prot_ff)}
	) else $error("read does not show active protection");

	a_full_prot: assert property (
		cmd_valid && in_pf && !prot_ff.protect_operation_enable &&
		prot_ff.high_range_disable && prot_ff.low_range_disable &&
		is_alter
		|=> cmd_refused_ff
	) else $error("full protection let an alteration through");

	a_no_prot: assert property (
		cmd_valid && run && !viol_ff && prot_ff.protect_operation_enable &&
		prot_ff.high_range_disable && prot_ff.low_range_disable
		|=> !cmd_refused_ff && !viol_ff
	) else $error("unprotected array refused a command");

endmodule : pfp_protect

// File: sim/test_pfp_protect.sv
`timescale 1ns/1ps

module test_pfp_protect import pfp_pkg::*; ();
	logic clk, rst, psel, penable, pwrite, special_mode;
	logic nv_rd_valid, nv_dbl_fault, cmd_valid;
	logic pready, pslverr, nv_rd_req, cmd_done, cmd_refused;
	logic protection_violation_flag, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] nv_rd_addr;
	logic [7:0] nv_rd_data, cur;
	pfp_cmd_t cmd;
	pfp_prot_t prot_cfg;
	int err_total, checks_done, seed;
	bit fl, sm;
	// allowed targets per source scenario, bit n = scenario n
	bit [7:0] ok [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

	pfp_protect dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .special_mode(special_mode),
		.nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr),
		.nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
		.nv_dbl_fault(nv_dbl_fault), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_done(cmd_done), .cmd_refused(cmd_refused),
		.protection_violation_flag(protection_violation_flag),
		.prot_cfg(prot_cfg));

	always #4 clk = ~clk;

	function automatic logic [2:0] scen(logic [7:0] p);
		return {p[7], p[2], p[5]};
	endfunction : scen

	function automatic bit prot(logic [7:0] p, logic [23:0] a);
		bit r;
		r = (!p[5] && a > 24'hFF_FFFF - (24'h00_0800 << p[4:3])) ||
			(!p[2] && a < 24'hFF_8000 + (24'h00_0400 << p[1:0]));
		if (a < 24'hFF_8000) return 1'b0;
		return p[7] ? r : !r;
	endfunction : prot

	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		slv = pslverr;
		if (n == 40) chk("apb wait", 0, 1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task load(input bit dbl, input logic [7:0] d);
		int n;
		n = 0;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		while (nv_rd_req !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		nv_rd_valid <= 1'b1;
		nv_rd_data <= d;
		nv_dbl_fault <= dbl;
		@(posedge clk);
		nv_rd_valid <= 1'b0;
		nv_dbl_fault <= 1'b0;
		@(posedge clk);
		cur = dbl ? 8'h7F : d;
		fl = 0;
		chk("nv addr", {8'h00, nv_rd_addr}, 32'h00FF_FE0C);
		chk("nv req", {31'h0, nv_rd_req}, 0);
		apb(1'b0, 12'h000, 0);
		chk("prot load", rd, {24'h0, cur});
		apb(1'b0, 12'h004, 0);
		chk("status", rd, {30'h0, dbl, 1'b1});
	endtask : load

	task wr_prot(input logic [7:0] w);
		logic [7:0] nx;
		nx = {w[7], cur[6], w[5], (cur[5] || sm) ? w[4:3] : cur[4:3],
			w[2], (cur[2] || sm) ? w[1:0] : cur[1:0]};
		if (sm || ok[scen(cur)][scen(nx)]) cur = nx;
		apb(1'b1, 12'h000, {24'h0, w});
		chk("prot err", {31'h0, slv}, 0);
		apb(1'b0, 12'h000, 0);
		chk("prot", rd, {24'h0, cur});
		chk("prot cfg", {24'h0, prot_cfg}, {24'h0, cur});
		apb(1'b0, 12'h008, 0);
		chk("scenario", rd, {29'h0, scen(cur)});
	endtask : wr_prot

	task cmd_try(input pfp_op_t op, input logic [23:0] a);
		bit hit;
		if (op == PFP_OP_BLOCK_ERASE) hit = a >= 24'hFF_8000 && scen(cur) != 3'd7;
		else hit = op != PFP_OP_OTHER && prot(cur, a);
		cmd_valid <= 1'b1;
		cmd <= {op, a};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
		chk("cmd done", cmd_done, 1);
		chk("cmd refused", cmd_refused, fl || hit);
		@(posedge clk);
		#1;
		fl = fl || hit;
		chk("viol flag", protection_violation_flag, fl);
		@(posedge clk);
	endtask : cmd_try

	initial begin
		#(8 * 40000);
		err_total++;
		complete_run;
	end

	initial begin
		clk = 0;
		rst = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		special_mode = 0;
		nv_rd_valid = 0;
		nv_rd_data = 0;
		nv_dbl_fault = 0;
		cmd_valid = 0;
		cmd = '0;
		seed = 32'h66c8;
		load(1'b1, 8'hA5);
		apb(1'b0, 12'h010, 0);
		chk("unmapped err", {31'h0, slv}, 1);
		chk("unmapped data", rd, 0);
		$display("test done: fault load and unmapped access");
		for (int k = 0; k < 6; k++) begin
			// keep the reserved bit erased in the stored byte
			load(1'b0, 8'($random(seed)) | 8'h40);
			for (int i = 0; i < 24; i++) begin
				sm = i >= 18;
				special_mode <= sm;
				@(posedge clk);
				wr_prot(8'($random(seed)));
				cmd_try(pfp_op_t'(2'($random(seed))),
					{(i % 4 == 3) ? 8'hFE : 8'hFF, 16'($random(seed))});
				for (int j = 0; j < 3 && i % 6 == 0; j++) begin
					// edges of the two ranges
					cmd_try(pfp_op_t'(2'(j)),
						24'hFF_FFFF - (24'h00_0800 << cur[4:3]) + 24'h1);
					cmd_try(pfp_op_t'(2'(j)),
						24'hFF_8000 + (24'h00_0400 << cur[1:0]) - 24'h1);
					cmd_try(pfp_op_t'(2'(j)), 24'hFF_FFFF);
					cmd_try(pfp_op_t'(2'(j)), 24'hFF_8000);
				end
				if (fl) begin
					cmd_try(PFP_OP_OTHER, 24'h00_0000);
					apb(1'b1, 12'h004, 32'h10);
					fl = 0;
					chk("flag clear", protection_violation_flag, 0);
				end
			end
			// open the top sector before the byte is reprogrammed
			wr_prot(8'hFF);
			cmd_try(PFP_OP_PROGRAM, 24'hFF_FE0C);
			$display("test done: reload pass %0d", k);
		end
		complete_run;
	end
endmodule : test_pfp_protect
